/* File: rtl/asp_pkg.sv */
// constants and types shared by the converter serial port
// assumes: used by asp_serial_port and asp_pair_buf, always through asp_pkg::name
package asp_pkg;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam logic [3:0] LAST_BIT = 4'hF;
	localparam int TX_SAMPLE_W = 10;
	localparam int RX_SAMPLE_W = 16;

	// ----------------------------------------------------------------
	// payload width codes
	// ----------------------------------------------------------------
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_10 = 2'h1;
	localparam logic [1:0] WIDTH_12 = 2'h2;
	localparam logic [1:0] WIDTH_14 = 2'h3;
	localparam logic [15:0] MASK_8 = 16'h00FF;
	localparam logic [15:0] MASK_10 = 16'h03FF;
	localparam logic [15:0] MASK_12 = 16'h0FFF;
	localparam logic [15:0] MASK_14 = 16'h3FFF;

	// ----------------------------------------------------------------
	// gain codes
	// ----------------------------------------------------------------
	localparam logic [1:0] GAIN_DIV1 = 2'h0;
	localparam logic [1:0] GAIN_DIV2 = 2'h1;
	localparam logic [1:0] GAIN_MUL2 = 2'h2;
	localparam logic [1:0] GAIN_MUL4 = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	// serial clock is the link clock divided by this figure
	localparam int LINK_DIV = 2;
	localparam int SCLK_MAX_HZ = 25_000_000;
	localparam int LINK_MAX_HZ = SCLK_MAX_HZ * LINK_DIV;
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic SEL_IDLE = 1'b1;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [3:0] BIT_RST = 4'h0;

	// ----------------------------------------------------------------
	// per-channel sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ASP_IDLE = 3'b001,
		ASP_SHIFT = 3'b010,
		ASP_GAP = 3'b100
	} asp_chan_state_t;

endpackage

/* File: rtl/asp_pair_buf.sv */
// two-entry buffer with valid and ready on both sides
// assumes: one clock, input side held until taken
`timescale 1ns/1ns
`default_nettype none

module asp_pair_buf #(
	parameter int W = asp_pkg::RX_SAMPLE_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// filling side
	input wire logic inValid,
	input wire logic [W-1:0] inData,
	output logic inReady,
	// draining side
	output logic outValid,
	output logic [W-1:0] outData,
	input wire logic outReady
);

	logic [W-1:0] head_reg, head_next;
	logic [W-1:0] tail_reg, tail_next;
	logic [1:0] count_reg, count_next;
	logic push, pop;

	assign inReady = (count_reg != 2'h2);
	assign outValid = (count_reg != 2'h0);
	assign outData = head_reg;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		head_next = head_reg;
		tail_next = tail_reg;
		count_next = count_reg;
		case ({push, pop})
			2'b10: begin
				if (count_reg == 2'h0) begin
					head_next = inData;
				end else begin
					tail_next = inData;
				end
				count_next = count_reg + 2'h1;
			end
			2'b01: begin
				head_next = tail_reg;
				count_next = count_reg - 2'h1;
			end
			2'b11: begin
				// with one entry the new word becomes head; two entries never push
				if (count_reg == 2'h1) begin
					head_next = inData;
				end else begin
					head_next = tail_reg;
					tail_next = inData;
				end
			end
			default: begin
				count_next = count_reg;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			head_reg <= '0;
			tail_reg <= '0;
			count_reg <= 2'h0;
		end else begin
			head_reg <= head_next;
			tail_reg <= tail_next;
			count_reg <= count_next;
		end
	end

endmodule

`default_nettype wire

/* File: rtl/asp_serial_port.sv */
// converter serial port: master link to an ADC (receive) and a DAC (transmit)
// assumes: afeClk is the converter-side oscillator, at most LINK_MAX_HZ;
// configuration ports change only while both channels are idle
`timescale 1ns/1ns
`default_nettype none

module asp_serial_port (
	// system clock domain
	input wire logic sys_clk,
	input wire logic arst_n,
	// converter-side clock
	input wire logic afeClk,
	// configuration
	input wire logic [1:0] cfgWidth,
	input wire logic [3:0] cfgPos,
	input wire logic [15:0] cfgTxFill,
	input wire logic cfgCpol,
	input wire logic cfgCpha,
	input wire logic cfgOffsetBinary,
	input wire logic [1:0] cfgGain,
	input wire logic cfgRxEnable,
	// transmit samples from the physical layer
	input wire logic txSampleValid,
	input wire logic [asp_pkg::TX_SAMPLE_W-1:0] txSampleData,
	output logic txSampleReady,
	// receive samples toward the physical layer
	output logic rxSampleValid,
	output logic [asp_pkg::RX_SAMPLE_W-1:0] rxSampleData,
	input wire logic rxSampleReady,
	// ADC pins
	output logic rxSerialClock,
	output logic rxSelectN,
	input wire logic rxSerialIn,
	// DAC pins
	output logic txSerialClock,
	output logic txSelectN,
	output logic txSerialOut
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] widthMask(input logic [1:0] w);
		logic [15:0] m;
		m = asp_pkg::MASK_8;
		case (w)
			asp_pkg::WIDTH_8: m = asp_pkg::MASK_8;
			asp_pkg::WIDTH_10: m = asp_pkg::MASK_10;
			asp_pkg::WIDTH_12: m = asp_pkg::MASK_12;
			asp_pkg::WIDTH_14: m = asp_pkg::MASK_14;
			default: m = asp_pkg::MASK_8;
		endcase
		return m;
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	// system side
	logic txReqTgl_reg, txReqTgl_next;
	logic [15:0] txFrame_reg, txFrame_next;
	logic rxAckTgl_reg, rxAckTgl_next;
	logic [1:0] l2sS1_reg, l2sS2_reg, l2sS3_reg, l2sStable_reg, l2sStable_next;
	logic [15:0] mask, placedMask, payloadTx, payloadRx, msbBit, signedRx;
	logic [15:0] gainedRx;
	logic rxNew, bufInReady, rxPush;
	// link side
	logic [4:0] s2lVec;
	logic [4:0] s2lS1_reg, s2lS2_reg, s2lS3_reg, s2lStable_reg, s2lStable_next;
	logic lnkTxReq, lnkRxAck, lnkCpol, lnkCpha, lnkRxEn;
	asp_pkg::asp_chan_state_t rxState_reg, rxState_next, txState_reg, txState_next;
	logic rxHalf_reg, rxHalf_next, txHalf_reg, txHalf_next;
	logic [3:0] rxBit_reg, rxBit_next, txBit_reg, txBit_next;
	logic [15:0] rxShift_reg, rxShift_next, txShift_reg, txShift_next;
	logic [15:0] rxHold_reg, rxHold_next, rxShiftIn;
	logic rxReqTgl_reg, rxReqTgl_next, txAckTgl_reg, txAckTgl_next;
	logic rxSclk_reg, rxSclk_next, txSclk_reg, txSclk_next;
	logic rxSel_reg, rxSel_next, txSel_reg, txSel_next;
	logic txOut_reg, txOut_next;

	// ----------------------------------------------------------------
	// system side: transmit framing, receive conversion
	// ----------------------------------------------------------------
	assign mask = widthMask(cfgWidth);
	assign placedMask = mask << cfgPos;
	// a word is offered only while the link has taken the previous one
	assign txSampleReady = (txReqTgl_reg == l2sStable_reg[1]);
	assign rxNew = (l2sStable_reg[0] != rxAckTgl_reg);
	// a full buffer leaves the toggle unanswered, which holds off the next ADC frame
	assign rxPush = rxNew && bufInReady;

	always_comb begin
		// ten-bit sample trimmed or zero-padded to the payload width
		payloadTx = {6'h00, txSampleData};
		case (cfgWidth)
			asp_pkg::WIDTH_8: payloadTx = {8'h00, txSampleData[9:2]};
			asp_pkg::WIDTH_10: payloadTx = {6'h00, txSampleData};
			asp_pkg::WIDTH_12: payloadTx = {4'h0, txSampleData, 2'b00};
			asp_pkg::WIDTH_14: payloadTx = {2'h0, txSampleData, 4'h0};
			default: payloadTx = {6'h00, txSampleData};
		endcase
	end

	always_comb begin
		payloadRx = (rxHold_reg >> cfgPos) & mask;
		msbBit = mask ^ (mask >> 1);
		if (cfgOffsetBinary) begin
			payloadRx = payloadRx ^ msbBit;
		end
		// signed data passes untouched apart from sign extension
		signedRx = ((payloadRx & msbBit) != 16'h0000) ? (payloadRx | ~mask) : payloadRx;
		gainedRx = signedRx;
		case (cfgGain)
			asp_pkg::GAIN_DIV1: gainedRx = signedRx;
			asp_pkg::GAIN_DIV2: gainedRx = {signedRx[15], signedRx[15:1]};
			asp_pkg::GAIN_MUL2: gainedRx = {signedRx[14:0], 1'b0};
			asp_pkg::GAIN_MUL4: gainedRx = {signedRx[13:0], 2'b00};
			default: gainedRx = signedRx;
		endcase
	end

	always_comb begin
		txReqTgl_next = txReqTgl_reg;
		txFrame_next = txFrame_reg;
		rxAckTgl_next = rxAckTgl_reg;
		// a level settles once the second and third stage agree
		l2sStable_next = (~(l2sS2_reg ^ l2sS3_reg) & l2sS3_reg)
			| ((l2sS2_reg ^ l2sS3_reg) & l2sStable_reg);
		if (txSampleValid && txSampleReady) begin
			txFrame_next = (cfgTxFill & ~placedMask) | ((payloadTx << cfgPos) & placedMask);
			txReqTgl_next = !txReqTgl_reg;
		end
		if (rxPush) begin
			rxAckTgl_next = !rxAckTgl_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			txReqTgl_reg <= 1'b0;
			txFrame_reg <= asp_pkg::WORD_RST;
			rxAckTgl_reg <= 1'b0;
			l2sS1_reg <= 2'h0;
			l2sS2_reg <= 2'h0;
			l2sS3_reg <= 2'h0;
			l2sStable_reg <= 2'h0;
		end else begin
			txReqTgl_reg <= txReqTgl_next;
			txFrame_reg <= txFrame_next;
			rxAckTgl_reg <= rxAckTgl_next;
			l2sS1_reg <= {txAckTgl_reg, rxReqTgl_reg};
			l2sS2_reg <= l2sS1_reg;
			l2sS3_reg <= l2sS2_reg;
			l2sStable_reg <= l2sStable_next;
		end
	end

	asp_pair_buf #(
		.W(asp_pkg::RX_SAMPLE_W)
	) rxBuf (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.inValid(rxNew),
		.inData(gainedRx),
		.inReady(bufInReady),
		.outValid(rxSampleValid),
		.outData(rxSampleData),
		.outReady(rxSampleReady)
	);

	// ----------------------------------------------------------------
	// link side: both channels run on the converter clock
	// ----------------------------------------------------------------
	assign s2lVec = {cfgRxEnable, cfgCpha, cfgCpol, rxAckTgl_reg, txReqTgl_reg};
	assign lnkTxReq = s2lStable_reg[0];
	assign lnkRxAck = s2lStable_reg[1];
	assign lnkCpol = s2lStable_reg[2];
	assign lnkCpha = s2lStable_reg[3];
	assign lnkRxEn = s2lStable_reg[4];
	// the ADC answers on our own serial clock, so its data is sampled directly
	assign rxShiftIn = {rxShift_reg[14:0], rxSerialIn};

	// receive channel: the device drives clock and select, only reads data
	always_comb begin
		rxState_next = rxState_reg;
		rxHalf_next = rxHalf_reg;
		rxBit_next = rxBit_reg;
		rxShift_next = rxShift_reg;
		rxHold_next = rxHold_reg;
		rxReqTgl_next = rxReqTgl_reg;
		rxSclk_next = rxSclk_reg;
		rxSel_next = rxSel_reg;
		s2lStable_next = (~(s2lS2_reg ^ s2lS3_reg) & s2lS3_reg)
			| ((s2lS2_reg ^ s2lS3_reg) & s2lStable_reg);
		case (rxState_reg)
			asp_pkg::ASP_IDLE: begin
				rxSclk_next = lnkCpol;
				// start only once the previous word was taken by the system side
				if (lnkRxEn && (lnkRxAck == rxReqTgl_reg)) begin
					rxState_next = asp_pkg::ASP_SHIFT;
					rxSel_next = 1'b0;
					rxHalf_next = 1'b0;
					rxBit_next = asp_pkg::BIT_RST;
				end
			end
			asp_pkg::ASP_SHIFT: begin
				if (!rxHalf_reg) begin
					rxHalf_next = 1'b1;
					rxSclk_next = !lnkCpol;
					if (!lnkCpha) begin
						rxShift_next = rxShiftIn;
					end
				end else begin
					rxHalf_next = 1'b0;
					rxSclk_next = lnkCpol;
					if (lnkCpha) begin
						rxShift_next = rxShiftIn;
					end
					if (rxBit_reg == asp_pkg::LAST_BIT) begin
						rxState_next = asp_pkg::ASP_GAP;
						rxSel_next = asp_pkg::SEL_IDLE;
						rxHold_next = lnkCpha ? rxShiftIn : rxShift_reg;
						rxReqTgl_next = !rxReqTgl_reg;
					end else begin
						rxBit_next = rxBit_reg + 4'h1;
					end
				end
			end
			asp_pkg::ASP_GAP: begin
				rxState_next = asp_pkg::ASP_IDLE;
			end
			default: begin
				rxState_next = asp_pkg::ASP_IDLE;
				rxSel_next = asp_pkg::SEL_IDLE;
			end
		endcase
	end

	// transmit channel: the device drives clock, select and data, reads nothing
	always_comb begin
		txState_next = txState_reg;
		txHalf_next = txHalf_reg;
		txBit_next = txBit_reg;
		txShift_next = txShift_reg;
		txAckTgl_next = txAckTgl_reg;
		txSclk_next = txSclk_reg;
		txSel_next = txSel_reg;
		txOut_next = txOut_reg;
		case (txState_reg)
			asp_pkg::ASP_IDLE: begin
				txSclk_next = lnkCpol;
				if (lnkTxReq != txAckTgl_reg) begin
					// the frame is copied now, so the system side may prepare the next
					txState_next = asp_pkg::ASP_SHIFT;
					txAckTgl_next = !txAckTgl_reg;
					txSel_next = 1'b0;
					txHalf_next = 1'b0;
					txBit_next = asp_pkg::BIT_RST;
					if (lnkCpha) begin
						txShift_next = txFrame_reg;
					end else begin
						txOut_next = txFrame_reg[15];
						txShift_next = {txFrame_reg[14:0], 1'b0};
					end
				end
			end
			asp_pkg::ASP_SHIFT: begin
				if (!txHalf_reg) begin
					txHalf_next = 1'b1;
					txSclk_next = !lnkCpol;
					if (lnkCpha) begin
						txOut_next = txShift_reg[15];
						txShift_next = {txShift_reg[14:0], 1'b0};
					end
				end else begin
					txHalf_next = 1'b0;
					txSclk_next = lnkCpol;
					if (txBit_reg == asp_pkg::LAST_BIT) begin
						txState_next = asp_pkg::ASP_GAP;
						txSel_next = asp_pkg::SEL_IDLE;
					end else begin
						txBit_next = txBit_reg + 4'h1;
						if (!lnkCpha) begin
							txOut_next = txShift_reg[15];
							txShift_next = {txShift_reg[14:0], 1'b0};
						end
					end
				end
			end
			asp_pkg::ASP_GAP: begin
				txState_next = asp_pkg::ASP_IDLE;
			end
			default: begin
				txState_next = asp_pkg::ASP_IDLE;
				txSel_next = asp_pkg::SEL_IDLE;
			end
		endcase
	end

	// serial clock is afeClk / LINK_DIV, never derived from sys_clk
	always_ff @(posedge afeClk or negedge arst_n) begin
		if (!arst_n) begin
			s2lS1_reg <= 5'h00;
			s2lS2_reg <= 5'h00;
			s2lS3_reg <= 5'h00;
			s2lStable_reg <= 5'h00;
			rxState_reg <= asp_pkg::ASP_IDLE;
			rxHalf_reg <= 1'b0;
			rxBit_reg <= asp_pkg::BIT_RST;
			rxShift_reg <= asp_pkg::WORD_RST;
			rxHold_reg <= asp_pkg::WORD_RST;
			rxReqTgl_reg <= 1'b0;
			rxSclk_reg <= 1'b0;
			rxSel_reg <= asp_pkg::SEL_IDLE;
			txState_reg <= asp_pkg::ASP_IDLE;
			txHalf_reg <= 1'b0;
			txBit_reg <= asp_pkg::BIT_RST;
			txShift_reg <= asp_pkg::WORD_RST;
			txAckTgl_reg <= 1'b0;
			txSclk_reg <= 1'b0;
			txSel_reg <= asp_pkg::SEL_IDLE;
			txOut_reg <= 1'b0;
		end else begin
			s2lS1_reg <= s2lVec;
			s2lS2_reg <= s2lS1_reg;
			s2lS3_reg <= s2lS2_reg;
			s2lStable_reg <= s2lStable_next;
			rxState_reg <= rxState_next;
			rxHalf_reg <= rxHalf_next;
			rxBit_reg <= rxBit_next;
			rxShift_reg <= rxShift_next;
			rxHold_reg <= rxHold_next;
			rxReqTgl_reg <= rxReqTgl_next;
			rxSclk_reg <= rxSclk_next;
			rxSel_reg <= rxSel_next;
			txState_reg <= txState_next;
			txHalf_reg <= txHalf_next;
			txBit_reg <= txBit_next;
			txShift_reg <= txShift_next;
			txAckTgl_reg <= txAckTgl_next;
			txSclk_reg <= txSclk_next;
			txSel_reg <= txSel_next;
			txOut_reg <= txOut_next;
		end
	end

	// ----------------------------------------------------------------
	// pins: separate port per channel, master only
	// ----------------------------------------------------------------
	assign rxSerialClock = rxSclk_reg;
	assign rxSelectN = rxSel_reg;
	assign txSerialClock = txSclk_reg;
	assign txSelectN = txSel_reg;
	assign txSerialOut = txOut_reg;

endmodule

`default_nettype wire

/* File: dv/asp_port_checker_assertions.sv */
// concurrent checks on the converter serial port pins and sample handshakes
// assumes: bound onto asp_serial_port; configuration changes only while idle
`timescale 1ns/1ns
`default_nettype none

module asp_port_checker (
	// clocks and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic afeClk,
	// configuration
	input wire logic cfgCpol,
	input wire logic cfgCpha,
	// sample handshakes
	input wire logic txSampleValid,
	input wire logic txSampleReady,
	input wire logic rxSampleValid,
	input wire logic [15:0] rxSampleData,
	input wire logic rxSampleReady,
	// converter pins
	input wire logic rxSerialClock,
	input wire logic rxSelectN,
	input wire logic txSerialClock,
	input wire logic txSelectN,
	input wire logic txSerialOut
);
	// ----------------------------------------------------------------
	// select low-time counters: a repetition of 32 would unroll badly
	// ----------------------------------------------------------------
	logic [5:0] txLow_reg, txLow_next, rxLow_reg, rxLow_next;
	always_comb begin
		txLow_next = txSelectN ? 6'h00 : txLow_reg + 6'h01;
		rxLow_next = rxSelectN ? 6'h00 : rxLow_reg + 6'h01;
	end
	always_ff @(posedge afeClk or negedge arst_n) begin
		if (!arst_n) begin
			txLow_reg <= 6'h00;
			rxLow_reg <= 6'h00;
		end else begin
			txLow_reg <= txLow_next;
			rxLow_reg <= rxLow_next;
		end
	end
	tx_frame_len_a:
		assert property (@(posedge afeClk) disable iff (!arst_n)
		$rose(txSelectN) |-> txLow_reg == 6'h20) else $error("tx frame not 32 cycles");
	rx_frame_len_a:
		assert property (@(posedge afeClk) disable iff (!arst_n)
		$rose(rxSelectN) |-> rxLow_reg == 6'h20) else $error("rx frame not 32 cycles");
	tx_low_max_a:
		assert property (@(posedge afeClk) disable iff (!arst_n)
		txLow_reg <= 6'h20) else $error("tx select low too long");
	tx_clk_toggle_a:
		assert property (@(posedge afeClk) disable iff (!arst_n)
		!txSelectN && !$past(txSelectN) |-> txSerialClock != $past(txSerialClock))
		else $error("tx serial clock not afeClk over two");
	rx_clk_toggle_a:
		assert property (@(posedge afeClk) disable iff (!arst_n)
		!rxSelectN && !$past(rxSelectN) |-> rxSerialClock != $past(rxSerialClock))
		else $error("rx serial clock not afeClk over two");
	tx_clk_start_a:
		assert property (@(posedge afeClk) disable iff (!arst_n)
		$fell(txSelectN) |-> txSerialClock == cfgCpol) else $error("tx clock not at idle level");
	tx_data_edge_a:
		assert property (@(posedge afeClk) disable iff (!arst_n)
		!txSelectN && !$past(txSelectN) && !$stable(txSerialOut)
		|-> txSerialClock == (cfgCpol ^ cfgCpha)) else $error("tx data moved on sampling edge");
	tx_gap_a:
		assert property (@(posedge afeClk) disable iff (!arst_n)
		$rose(txSelectN) |-> txSelectN [*2]) else $error("tx frame gap too short");
	rx_hold_a:
		assert property (@(posedge sys_clk) disable iff (!arst_n)
		rxSampleValid && !rxSampleReady |=> rxSampleValid && $stable(rxSampleData))
		else $error("rx word dropped or changed while stalled");
	tx_start_bound_a:
		assert property (@(posedge sys_clk) disable iff (!arst_n)
		txSampleValid && txSampleReady |=> !txSampleReady ##[0:100] !txSelectN)
		else $error("tx frame did not start");
	cover property (@(posedge afeClk) disable iff (!arst_n) $rose(txSelectN));
	cover property (@(posedge afeClk) disable iff (!arst_n) $rose(rxSelectN));
	cover property (@(posedge sys_clk) disable iff (!arst_n) rxSampleValid && !rxSampleReady);
endmodule

bind asp_serial_port asp_port_checker u_checker (.sys_clk(sys_clk), .arst_n(arst_n),
	.afeClk(afeClk), .cfgCpol(cfgCpol), .cfgCpha(cfgCpha), .txSampleValid(txSampleValid),
	.txSampleReady(txSampleReady), .rxSampleValid(rxSampleValid), .rxSampleData(rxSampleData),
	.rxSampleReady(rxSampleReady), .rxSerialClock(rxSerialClock), .rxSelectN(rxSelectN),
	.txSerialClock(txSerialClock), .txSelectN(txSelectN), .txSerialOut(txSerialOut));
`default_nettype wire

/* File: dv/asp_converter_model.sv */
// behavioural ADC and DAC on the far side of the converter serial port
// assumes: cpol and cpha match the port's configuration
`timescale 1ns/1ns
`default_nettype none

module asp_converter_model (
	// ADC pins
	input wire logic rxSerialClock,
	input wire logic rxSelectN,
	output var logic rxSerialIn,
	// DAC pins
	input wire logic txSerialClock,
	input wire logic txSelectN,
	input wire logic txSerialOut,
	// mode and traffic
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [15:0] adcWord,
	output var int adcFrames,
	output var int dacFrames,
	output var logic [15:0] dacWord
);
	int adcBit;
	int dacBit;
	logic [15:0] dacShift;
	initial begin
		rxSerialIn = 1'b0;
		adcFrames = 0;
		dacFrames = 0;
		dacWord = 16'h0000;
		adcBit = 16;
		dacBit = 0;
	end
	always @(negedge rxSelectN) begin
		adcBit = 15;
		if (!cpha) begin
			rxSerialIn = adcWord[15];
			adcBit = 14;
		end
	end
	always @(rxSerialClock) begin
		if (!rxSelectN && ((rxSerialClock ^ cpol) == cpha)) begin
			if (adcBit >= 0) rxSerialIn = adcWord[adcBit];
			else rxSerialIn = ~rxSerialIn;
			adcBit = adcBit - 1;
		end
	end
	// a released line shows the inverse, never the last bit
	always @(posedge rxSelectN) begin
		rxSerialIn = ~rxSerialIn;
		#1;
		if (adcBit < 0) adcFrames = adcFrames + 1;
	end
	always @(negedge txSelectN) dacBit = 0;
	// sampling ignores select: the last trailing edge may coincide with its rise
	always @(txSerialClock) begin
		if ((txSerialClock ^ cpol) != cpha) begin
			dacShift = {dacShift[14:0], txSerialOut};
			dacBit = dacBit + 1;
		end
	end
	always @(posedge txSelectN) begin
		#1;
		if (dacBit == 16) begin
			dacWord = dacShift;
			dacFrames = dacFrames + 1;
		end
	end
endmodule
`default_nettype wire

/* File: dv/asp_serial_port_tb_top.sv */
// self-checking bench for the converter serial port
// assumes: asp_converter_model on the pins, checker bound onto the port
`timescale 1ns/1ns
`default_nettype none

module asp_serial_port_tb_top;
	logic sys_clk, arst_n, afeClk, cfgCpol, cfgCpha, cfgOffsetBinary, cfgRxEnable;
	logic [1:0] cfgWidth, cfgGain;
	logic [3:0] cfgPos;
	logic [15:0] cfgTxFill, adcWord, dacWord, rxSampleData;
	logic txSampleValid, txSampleReady, rxSampleValid, rxSampleReady;
	logic [asp_pkg::TX_SAMPLE_W-1:0] txSampleData;
	logic rxSerialClock, rxSelectN, rxSerialIn, txSerialClock, txSelectN, txSerialOut;
	int adcFrames, dacFrames, n_errors, comparisons, cycles;

	asp_serial_port dut (.sys_clk(sys_clk), .arst_n(arst_n), .afeClk(afeClk),
		.cfgWidth(cfgWidth), .cfgPos(cfgPos), .cfgTxFill(cfgTxFill), .cfgCpol(cfgCpol),
		.cfgCpha(cfgCpha), .cfgOffsetBinary(cfgOffsetBinary), .cfgGain(cfgGain),
		.cfgRxEnable(cfgRxEnable), .txSampleValid(txSampleValid), .txSampleData(txSampleData),
		.txSampleReady(txSampleReady), .rxSampleValid(rxSampleValid),
		.rxSampleData(rxSampleData), .rxSampleReady(rxSampleReady),
		.rxSerialClock(rxSerialClock), .rxSelectN(rxSelectN), .rxSerialIn(rxSerialIn),
		.txSerialClock(txSerialClock), .txSelectN(txSelectN), .txSerialOut(txSerialOut));
	asp_converter_model model (.rxSerialClock(rxSerialClock), .rxSelectN(rxSelectN),
		.rxSerialIn(rxSerialIn), .txSerialClock(txSerialClock), .txSelectN(txSelectN),
		.txSerialOut(txSerialOut), .cpol(cfgCpol), .cpha(cfgCpha), .adcWord(adcWord),
		.adcFrames(adcFrames), .dacFrames(dacFrames), .dacWord(dacWord));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// link clock offset in phase from the system clock
	initial begin
		afeClk = 1'b0;
		#3;
		forever #40 afeClk = ~afeClk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic txOffer(input logic [9:0] s);
		int t;
		@(negedge sys_clk);
		txSampleValid = 1'b1;
		txSampleData = s;
		t = 0;
		// ready is looked at where it has settled; it holds into the next rising edge
		while (txSampleReady !== 1'b1 && t < 200) begin
			t++;
			@(negedge sys_clk);
		end
		check({15'h0000, txSampleReady}, 16'h0001);
		@(negedge sys_clk);
		txSampleValid = 1'b0;
	endtask
	task automatic waitDac(input int n);
		int t;
		t = 0;
		while (dacFrames < n && t < 2000) begin
			t++;
			@(negedge sys_clk);
		end
	endtask
	function automatic logic [15:0] txFrame(input logic [9:0] s);
		logic [15:0] pay, mask;
		case (cfgWidth)
			asp_pkg::WIDTH_8: begin
				pay = {8'h00, s[9:2]};
				mask = asp_pkg::MASK_8;
			end
			asp_pkg::WIDTH_10: begin
				pay = {6'h00, s};
				mask = asp_pkg::MASK_10;
			end
			asp_pkg::WIDTH_12: begin
				pay = {4'h0, s, 2'h0};
				mask = asp_pkg::MASK_12;
			end
			default: begin
				pay = {2'h0, s, 4'h0};
				mask = asp_pkg::MASK_14;
			end
		endcase
		return (cfgTxFill & ~(mask << cfgPos)) | (pay << cfgPos);
	endfunction
	function automatic logic [15:0] rxSample(input logic [15:0] f);
		logic [15:0] v;
		int n;
		n = 8 + 2 * cfgWidth;
		v = f >> cfgPos;
		if (cfgOffsetBinary) v[n-1] = ~v[n-1];
		for (int k = 0; k < 16; k++) if (k >= n) v[k] = v[n-1];
		case (cfgGain)
			asp_pkg::GAIN_DIV1: return v;
			asp_pkg::GAIN_DIV2: return $signed(v) >>> 1;
			asp_pkg::GAIN_MUL2: return v << 1;
			default: return v << 2;
		endcase
	endfunction

	// every width and clock mode, two samples back to back each
	task automatic txModes();
		int base;
		for (int i = 0; i < 4; i++) begin
			cfgWidth = i[1:0];
			cfgCpol = i[0];
			cfgCpha = i[1];
			cfgPos = 4'(i * 4);
			cfgTxFill = 16'hA5C3 ^ 16'(i);
			settle(150);
			base = dacFrames;
			txOffer(10'h2B7);
			txOffer(10'h1C9);
			waitDac(base + 1);
			check(dacWord, txFrame(10'h2B7));
			waitDac(base + 2);
			check(dacWord, txFrame(10'h1C9));
			check(16'(dacFrames - base), 16'h0002);
		end
		$display("tx modes done");
	endtask
	// every width, gain and clock mode with the consumer stalled until the buffer is full
	task automatic rxModes();
		int base, got;
		for (int i = 0; i < 4; i++) begin
			cfgWidth = i[1:0];
			cfgGain = i[1:0];
			cfgOffsetBinary = i[0];
			cfgCpol = i[1];
			cfgCpha = i[0] ^ i[1];
			cfgPos = 4'(6 - 2 * i);
			adcWord = 16'hC3A5 ^ {4{4'(i)}};
			settle(150);
			base = adcFrames;
			cfgRxEnable = 1'b1;
			settle(1500);
			cfgRxEnable = 1'b0;
			settle(800);
			got = 0;
			while (rxSampleValid === 1'b1 && got < 8) begin
				check(rxSampleData, rxSample(adcWord));
				rxSampleReady = 1'b1;
				settle(1);
				rxSampleReady = 1'b0;
				got++;
				settle(3);
			end
			check(16'(got), 16'(adcFrames - base));
			check(16'(got >= 2), 16'h0001);
		end
		$display("rx modes done");
	endtask
	// reset in the middle of a tx frame, then a clean frame
	task automatic resetMid();
		int base, t;
		txOffer(10'h155);
		t = 0;
		while (txSelectN !== 1'b0 && t < 200) begin
			t++;
			settle(1);
		end
		settle(50);
		arst_n = 1'b0;
		settle(30);
		check({13'h0000, txSelectN, rxSampleValid, txSampleReady}, 16'h0005);
		arst_n = 1'b1;
		settle(150);
		base = dacFrames;
		txOffer(10'h2AA);
		waitDac(base + 1);
		check(dacWord, txFrame(10'h2AA));
		$display("reset in frame done");
	endtask

	initial begin
		{cfgWidth, cfgGain, cfgPos, cfgCpol, cfgCpha, cfgOffsetBinary} = '0;
		{cfgRxEnable, txSampleValid, txSampleData, rxSampleReady} = '0;
		cfgTxFill = 16'h0000;
		adcWord = 16'h0000;
		n_errors = 0;
		comparisons = 0;
		cycles = 0;
		// held over three link clocks: the slower domain needs two edges
		arst_n = 1'b0;
		repeat (3) @(posedge afeClk);
		@(negedge sys_clk);
		arst_n = 1'b1;
		settle(150);
		txModes();
		rxModes();
		resetMid();
		summarize();
	end
endmodule
`default_nettype wire
